// >>> protected_port_forward_mask.sv
// Overview of operation
// (RULE1) promiscuous ingress reaches every private vlan port
// (RULE2) isolated ingress reaches only promiscuous ports
// (RULE3) protected egress only from promiscuous ingress
// (RULE4) promiscuous egress accepts any ingress port
// (RULE5) port class is global, not per vlan
// (RULE6) promiscuous ingress: egress equals vlan mask
// (RULE7) isolated ingress: private mask narrows vlan mask
// (RULE8) software sets vlan membership before protection
// (RULE9) all ports unprotected after reset
// (RULE10) protected and unprotected port sets readable
// (RULE11) private mask ANDed for protected ingress
//
// per-port protection class store and registered egress mask lookup
// assumes the forwarding engine and the management logic share clk;
// a request is answered one cycle later, no back-pressure
`timescale 1ns/1ns
`include "pfm_defs.svh"

module protected_port_forward_mask #(
    parameter int NUM_PORTS = `PFM_DEFAULT_PORTS,
    parameter int PW        = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1
) (
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    input  wire logic                    cfg_write,
    input  wire logic [PW-1:0]           cfg_port,
    input  wire pfm_pkg::port_class_type cfg_class,
    input  wire logic                    cfg_bulk_write,
    input  wire logic [NUM_PORTS-1:0]    cfg_bulk_protect,
    input  wire logic                    req_valid,
    input  wire logic [PW-1:0]           req_ingress_port,
    input  wire logic [NUM_PORTS-1:0]    req_vlan_mask,
    output logic                         fwd_valid,
    output logic      [NUM_PORTS-1:0]    fwd_mask,
    output logic                         fwd_ingress_protected,
    output logic                         fwd_bad_port,
    output logic      [NUM_PORTS-1:0]    protected_ports,
    output logic      [NUM_PORTS-1:0]    unprotected_ports
);

    // ===================================================================
    // elaboration checks
    // ===================================================================
    generate
        if (NUM_PORTS < 2 || NUM_PORTS > `PFM_MAX_PORTS) begin : g_bad_ports
            $error("NUM_PORTS out of supported range");
        end
        if (PW < $clog2(NUM_PORTS)) begin : g_bad_pw
            $error("PW too narrow for NUM_PORTS");
        end
    endgenerate

    // ===================================================================
    // helpers
    // ===================================================================
    function automatic logic port_valid(input logic [PW-1:0] idx);
        port_valid = (int'(idx) < NUM_PORTS);
    endfunction

    function automatic logic class_of(input logic [NUM_PORTS-1:0] vec,
                                      input logic [PW-1:0]        idx);
        class_of = port_valid(idx) ? vec[idx] : `PFM_CLASS_RESET;
    endfunction

    function automatic logic [NUM_PORTS-1:0] port_onehot(input logic [PW-1:0] idx);
        logic [NUM_PORTS-1:0] one;
        one         = {{(NUM_PORTS-1){1'b0}}, 1'b1};
        port_onehot = port_valid(idx) ? (one << idx) : '0;
    endfunction

    // ===================================================================
    // reset synchroniser
    // ===================================================================
    logic rst_meta;
    logic rst_sync;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= `PFM_RST_ASSERTED;
            rst_sync <= `PFM_RST_ASSERTED;
        end else begin
            rst_meta <= `PFM_RST_RELEASED;
            rst_sync <= rst_meta;
        end
    end

    // ===================================================================
    // port class store
    // ===================================================================
    // a single vector serves every vlan, so one write reclassifies a port
    // everywhere at once; there is deliberately no per-vlan copy
    logic [NUM_PORTS-1:0] protect_vec;

    // bulk load lands first, a single-port write in the same cycle wins
    // for its own bit; an out-of-range port index is ignored
    wire [NUM_PORTS-1:0] bulk_base      = cfg_bulk_write ? cfg_bulk_protect : protect_vec;
    wire [NUM_PORTS-1:0] cfg_bit        = port_onehot(cfg_port);
    wire                 cfg_to_protect = (cfg_class == pfm_pkg::port_protected);
    wire [NUM_PORTS-1:0] single_result  = cfg_to_protect ? (bulk_base | cfg_bit) : (bulk_base & ~cfg_bit);
    wire [NUM_PORTS-1:0] next_protect   = cfg_write ? single_result : bulk_base;   // [RULE5]

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            protect_vec <= {NUM_PORTS{`PFM_CLASS_RESET}};                        // [RULE9]
        end else begin
            protect_vec <= next_protect;
        end
    end

    assign protected_ports   = protect_vec;                                      // [RULE10]
    assign unprotected_ports = ~protect_vec;                                     // [RULE10]

    // ===================================================================
    // egress mask lookup
    // ===================================================================
    // the protection mask can only remove ports from the vlan result, so
    // without vlan membership set up first nothing is forwarded at all
    wire                 req_port_ok       = port_valid(req_ingress_port);
    wire                 ingress_protected = class_of(protect_vec, req_ingress_port);   // [RULE3]
    wire [NUM_PORTS-1:0] egress_mask;

    pv_mask_calc #(
        .NUM_PORTS (NUM_PORTS)
    ) u_mask_calc (
        .protect_vec       (protect_vec),
        .ingress_protected (ingress_protected),
        .port_ok           (req_port_ok),
        .vlan_mask         (req_vlan_mask),
        .egress_mask       (egress_mask)
    );

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            fwd_valid <= 1'b0;
        end else begin
            fwd_valid <= req_valid;
        end
    end

    // result words hold between requests so a slow consumer may reread them
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            fwd_mask              <= '0;
            fwd_ingress_protected <= 1'b0;
            fwd_bad_port          <= 1'b0;
        end else if (req_valid) begin
            fwd_mask              <= egress_mask;                                // [RULE4] [RULE6] [RULE7]
            fwd_ingress_protected <= ingress_protected;
            fwd_bad_port          <= !req_port_ok;
        end
    end

    // ===================================================================
    // assertions
    // ===================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync);

    a_promisc_full_reach: assert property (                                      // [RULE1]
        req_valid && req_port_ok && !ingress_protected |=> fwd_mask == $past(req_vlan_mask))
        else $error("promiscuous ingress did not reach whole vlan");

    a_isolated_no_peer: assert property (                                        // [RULE2]
        req_valid && ingress_protected |=> (fwd_mask & $past(protect_vec)) == '0)
        else $error("isolated ingress reached a protected port");

    a_protected_rx_only: assert property (                                       // [RULE3]
        fwd_valid && ((fwd_mask & $past(protect_vec, 1)) != '0) |-> !fwd_ingress_protected && !fwd_bad_port)
        else $error("protected egress from non-promiscuous ingress");

    a_promisc_rx_any: assert property (                                          // [RULE4]
        req_valid && req_port_ok |=>
            (fwd_mask & ~$past(protect_vec)) == ($past(req_vlan_mask) & ~$past(protect_vec)))
        else $error("promiscuous egress port dropped");

    a_class_global: assert property (                                            // [RULE5]
        !cfg_write && !cfg_bulk_write |=> $stable(protect_vec))
        else $error("port class changed without configuration");

    a_vlan_bound: assert property (                                              // [RULE6]
        req_valid |=> fwd_valid ##0 (fwd_mask & ~$past(req_vlan_mask)) == '0)
        else $error("egress mask exceeds vlan mask");

    a_isolated_narrow: assert property (                                         // [RULE7]
        req_valid && ingress_protected |=>
            (fwd_mask | ($past(req_vlan_mask) & $past(protect_vec))) == $past(req_vlan_mask))
        else $error("isolated ingress lost a promiscuous port");

    a_reset_unprot: assert property (                                            // [RULE9]
        $rose(rst_sync) |->
            protect_vec == '0 ##1 ($past(cfg_write) || $past(cfg_bulk_write) || protect_vec == '0))
        else $error("port protected after reset");

    a_readback_class: assert property (                                          // [RULE10]
        cfg_write && port_valid(cfg_port) |=>
            protected_ports[$past(cfg_port)] == $past(cfg_to_protect) &&
            unprotected_ports[$past(cfg_port)] == !$past(cfg_to_protect))
        else $error("readback does not show written class");

    a_pv_and: assert property (                                                  // [RULE11]
        req_valid && ingress_protected |=>
            fwd_ingress_protected && fwd_mask == ($past(req_vlan_mask) & ~$past(protect_vec)))
        else $error("private vlan mask not ANDed");

    a_bad_port_zero: assert property (
        req_valid && !req_port_ok |=> fwd_bad_port && fwd_mask == '0)
        else $error("unknown ingress port forwarded");

    a_valid_single: assert property (                                            // [RULE6]
        !req_valid |=> !fwd_valid)
        else $error("answer without a request");

    // a slow consumer rereads the result words, so idle cycles must not touch them
    a_result_hold: assert property (
        !req_valid |=> $stable(fwd_mask) && $stable(fwd_ingress_protected) && $stable(fwd_bad_port))
        else $error("result changed without a request");

    a_bulk_load: assert property (                                               // [RULE5]
        cfg_bulk_write && !cfg_write |=> protect_vec == $past(cfg_bulk_protect))
        else $error("bulk class load not taken");

    a_single_keep: assert property (                                             // [RULE5]
        cfg_write && !cfg_bulk_write |=>
            (protect_vec & ~$past(cfg_bit)) == ($past(protect_vec) & ~$past(cfg_bit)))
        else $error("single class write touched another port");

endmodule

// >>> pfm_defs.svh
// named constants for the protected-port forwarding mask block
// assumes inclusion by bare name from every file that needs these values
`ifndef PFM_DEFS_SVH
`define PFM_DEFS_SVH

// default port count: eight copper ports plus two fibre ports
`define PFM_DEFAULT_PORTS   10
// widest port set that one mask word may carry
`define PFM_MAX_PORTS       32
// class bit held by every port after reset (unprotected)
`define PFM_CLASS_RESET     1'b0
// reset level of the reset synchroniser stages
`define PFM_RST_ASSERTED    1'b0
`define PFM_RST_RELEASED    1'b1

`endif

// >>> pfm_pkg.sv
// types shared by the protected-port forwarding mask files
// assumes nothing of its surroundings
package pfm_pkg;

    // per-port class, one global setting for every private vlan
    typedef enum logic {
        port_unprotected,
        port_protected
    } port_class_type;

endpackage

// >>> pv_mask_calc.sv
// egress mask arithmetic: vlan-table mask, narrowed for isolated ingress
// assumes protect_vec, flags and vlan_mask all come from the same clock domain
`timescale 1ns/1ns
`include "pfm_defs.svh"

module pv_mask_calc #(
    parameter int NUM_PORTS = `PFM_DEFAULT_PORTS
) (
    input  wire logic [NUM_PORTS-1:0] protect_vec,
    input  wire logic                 ingress_protected,
    input  wire logic                 port_ok,
    input  wire logic [NUM_PORTS-1:0] vlan_mask,
    output logic      [NUM_PORTS-1:0] egress_mask
);

    // ===================================================================
    // private-vlan mask and selection
    // ===================================================================
    // one bit per port, set where the port is unprotected
    wire [NUM_PORTS-1:0] pv_mask       = ~protect_vec;                    // [RULE11]
    wire [NUM_PORTS-1:0] isolated_mask = vlan_mask & pv_mask;             // [RULE7] [RULE2]
    // unknown ingress port forwards nowhere rather than leaking a frame
    wire [NUM_PORTS-1:0] chosen_mask   = ingress_protected ? isolated_mask : vlan_mask;  // [RULE6] [RULE1]

    assign egress_mask = port_ok ? chosen_mask : '0;

endmodule

// >>> fwd_engine_model.sv
// forwarding engine stand-in: one registered lookup per ask from the bench
// assumes the bench drives the ask fields on the rising clock edge
`timescale 1ns/1ns
module fwd_engine_model #(
    parameter int N  = 10,
    parameter int PW = 4
) (
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire logic          ask,
    input  wire logic [PW-1:0] ask_port,
    input  wire logic [N-1:0]  ask_vlan,
    output logic               req_valid,
    output logic      [PW-1:0] req_ingress_port,
    output logic      [N-1:0]  req_vlan_mask
);
    // idle fields flip every cycle so a stale value is never trusted
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            req_valid        <= 1'b0;
            req_ingress_port <= {PW{1'b1}};
            req_vlan_mask    <= {N{1'b1}};
        end else begin
            req_valid        <= ask;
            req_ingress_port <= ask ? ask_port : ~req_ingress_port;
            req_vlan_mask    <= ask ? ask_vlan : ~req_vlan_mask;
        end
    end
endmodule

// >>> protected_port_forward_mask_tb_top.sv
// self-checking bench for the protected-port egress mask block
// assumes default port count; the engine model sits in front of the lookup port
`timescale 1ns/1ns
module protected_port_forward_mask_tb_top;
    localparam int N  = 10;
    localparam int PW = 4;
    logic                    clk, arst_n, cfg_write, cfg_bulk_write, ask, s_cw, s_cc, s_bw, s_ask;
    logic [PW-1:0]           cfg_port, ask_port, s_cp, s_ap, req_ingress_port;
    logic [N-1:0]            cfg_bulk_protect, ask_vlan, s_bp, s_av, req_vlan_mask, prot;
    logic [N-1:0]            fwd_mask, protected_ports, unprotected_ports, held;
    logic                    req_valid, fwd_valid, fwd_ingress_protected, fwd_bad_port;
    pfm_pkg::port_class_type cfg_class;
    int                      n_mismatch, comparisons, cycles;

    fwd_engine_model i_fwd_engine_model (.clk(clk), .arst_n(arst_n), .ask(ask), .ask_port(ask_port),
        .ask_vlan(ask_vlan), .req_valid(req_valid), .req_ingress_port(req_ingress_port),
        .req_vlan_mask(req_vlan_mask));
    protected_port_forward_mask i_protected_port_forward_mask (.clk(clk), .arst_n(arst_n),
        .cfg_write(cfg_write), .cfg_port(cfg_port), .cfg_class(cfg_class), .cfg_bulk_write(cfg_bulk_write),
        .cfg_bulk_protect(cfg_bulk_protect), .req_valid(req_valid), .req_ingress_port(req_ingress_port),
        .req_vlan_mask(req_vlan_mask), .fwd_valid(fwd_valid), .fwd_mask(fwd_mask),
        .fwd_ingress_protected(fwd_ingress_protected), .fwd_bad_port(fwd_bad_port),
        .protected_ports(protected_ports), .unprotected_ports(unprotected_ports));

    // ==============================================================
    // checking helpers
    task automatic chk(input logic [N-1:0] seen, input logic [N-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [N-1:0] want(input logic [N-1:0] pr, input logic [PW-1:0] p, input logic [N-1:0] m);
        if (p >= N) return {N{1'b0}};
        return pr[p] ? (m & ~pr) : m;
    endfunction

    task automatic conclude();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // one edge: predict from what the design samples, drive staged values, check
    task automatic step();
        logic v, bad, ip;
        logic [N-1:0] em;
        @(posedge clk);
        v   = req_valid;
        bad = req_ingress_port >= N;
        ip  = prot[req_ingress_port];
        em  = want(prot, req_ingress_port, req_vlan_mask);
        if (cfg_bulk_write) prot = cfg_bulk_protect;
        if (cfg_write && cfg_port < N) prot[cfg_port] = cfg_class;
        cfg_write <= s_cw; cfg_port <= s_cp; cfg_class <= pfm_pkg::port_class_type'(s_cc);
        cfg_bulk_write <= s_bw; cfg_bulk_protect <= s_bp; ask <= s_ask; ask_port <= s_ap; ask_vlan <= s_av;
        s_cw = 0; s_bw = 0; s_ask = 0;
        #1;
        chk(fwd_valid, v);
        if (v) begin
            chk(fwd_mask, em);
            chk(fwd_bad_port, bad);
            if (!bad) chk(fwd_ingress_protected, ip);
            held = em;
        end else begin
            chk(fwd_mask, held);
        end
        chk(protected_ports, prot);
        chk(unprotected_ports, ~prot);
    endtask

    // ==============================================================
    // clock and watchdog
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            n_mismatch++;
            conclude();
        end
    end

    // ==============================================================
    // tests
    initial begin
        arst_n = 0; cfg_write = 0; cfg_port = 0; cfg_class = pfm_pkg::port_unprotected; cfg_bulk_write = 0;
        cfg_bulk_protect = 0; ask = 0; ask_port = 0; ask_vlan = 0; prot = 0;
        held = 0;
        s_cw = 0; s_cp = 0; s_cc = 0; s_bw = 0; s_bp = 0; s_ask = 0; s_ap = 0; s_av = 0;
        void'($urandom(28565));
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        step();
        for (int p = 0; p < 16; p++) begin
            s_ask = 1; s_ap = PW'(p); s_av = 10'h3ff;
            step();
        end
        $display("test open_ports done");
        s_bw = 1; s_bp = 10'h2a5; s_cw = 1; s_cp = 4'h1; s_cc = 1;
        step();
        for (int p = 0; p < N; p++) begin
            s_ask = 1; s_ap = PW'(p); s_av = 10'h3ff;
            step();
        end
        s_bw = 1; s_bp = 10'h3ff; s_ask = 1; s_ap = 4'h4; s_av = 10'h3ff;
        step();
        repeat (3) step();
        $display("test isolation done");
        for (int i = 0; i < 3000; i++) begin
            s_cw = ($urandom % 4) == 0; s_cp = PW'($urandom); s_cc = 1'($urandom);
            s_bw = ($urandom % 16) == 0; s_bp = N'($urandom);
            s_ask = 1'($urandom); s_ap = PW'($urandom % 12); s_av = N'($urandom);
            step();
        end
        repeat (3) step();
        $display("test random done");
        @(posedge clk);
        arst_n <= 1'b0;
        #1;
        chk(protected_ports, 10'h000);
        chk(fwd_valid, 1'b0);
        chk(fwd_mask, 10'h000);
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        prot = 0;
        held = 0;
        repeat (3) @(posedge clk);
        s_ask = 1; s_ap = 4'h3; s_av = 10'h155;
        repeat (3) step();
        $display("test mid_reset done");
        conclude();
    end
endmodule
